// ==== hw/pmrd_pkg.sv ====
`default_nettype none
package pmrd_pkg;
	// Core clock rate and the millisecond tick derived from it.
	localparam int CLK_FREQ_KHZ = 50000;
	localparam int TICK_TIME_MS = 1;
	localparam int TICK_CYCLES = TICK_TIME_MS * CLK_FREQ_KHZ;
	// Strobe qualification and timer scaling, counted in milliseconds.
	localparam logic [2:0] STB_MIN_MS = 3'h3;
	localparam logic [11:0] DEB_UNIT_MS = 12'h00a;
	localparam int DEB_CNT_W = 12;
	// Register bus geometry and byte offsets.
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_TIMING = 5'h04;
	localparam logic [4:0] OFF_MSGCFG = 5'h08;
	localparam logic [4:0] OFF_STATUS = 5'h0c;
	// Field positions.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DPOL_BIT = 3;
	localparam int CTRL_CPOL_BIT = 4;
	localparam int CTRL_DEFEN_BIT = 5;
	localparam int TIM_SAMP_LSB = 0;
	localparam int TIM_DEB_LSB = 8;
	localparam int CFG_DEF_LSB = 0;
	localparam int CFG_LAST_LSB = 8;
	localparam int STAT_MSG_LSB = 0;
	localparam int STAT_CNT_LSB = 8;
	localparam int STAT_PORT_LSB = 16;
	localparam int STAT_BUSY_BIT = 24;
	// Reset values.
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [7:0] SAMP_RST = 8'h05;
	localparam logic [7:0] DEB_RST = 8'h05;
	localparam logic [7:0] DEFMSG_RST = 8'h00;
	localparam logic [7:0] LASTPROG_RST = 8'hff;
	localparam logic [2:0] PTR_RST = 3'h7;
	// Request modes.
	localparam logic [2:0] MODE_BCD8 = 3'h0;
	localparam logic [2:0] MODE_BCD4 = 3'h1;
	localparam logic [2:0] MODE_BCD9 = 3'h2;
	localparam logic [2:0] MODE_PER_LINE = 3'h3;
	localparam logic [2:0] MODE_WHOLE = 3'h4;
	// Message numbering for the per-line mode, and the number and digit limits of the BCD modes.
	localparam logic [7:0] PL_ACT_BASE = 8'h01;
	localparam logic [7:0] PL_INACT_BASE = 8'h0b;
	localparam logic [9:0] MSG_MAX = 10'h0ff;
	localparam logic [3:0] BCD_MAX = 4'h9;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Strobe sequencer states, Gray coded along the path.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_QUAL = 2'h1,
		ST_SAMP = 2'h3,
		ST_HOLD = 2'h2
	} pmrd_stb_t;
endpackage
`default_nettype wire

// ==== hw/pmrd_sync.sv ====
`default_nettype none
module pmrd_sync #(
	parameter int W = 10
) (
	// Clocking.
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	// Pins in, synchronised levels out.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pmrd_sync_t;
	pmrd_sync_t st_reg, st_next;

	if (W < 1) begin : g_chk
		$error("pmrd_sync width must be positive");
	end

	// The first stage feeds only the second stage.
	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule
`default_nettype wire

// ==== hw/pmrd_tick.sv ====
`default_nettype none
module pmrd_tick #(
	parameter int CYC = pmrd_pkg::TICK_CYCLES
) (
	// Clocking.
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	// One-cycle pulse every CYC cycles.
	output logic tick
);
	localparam int CW = $clog2(CYC);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic tick;
	} pmrd_tick_t;
	pmrd_tick_t st_reg, st_next;

	if (CYC < 2) begin : g_chk
		$error("pmrd_tick needs at least two cycles per tick");
	end

	// Free-running divider; the pulse is registered so it is glitch free.
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == CW'(CYC - 1)) begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + CW'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;
endmodule
`default_nettype wire

// ==== hw/pmrd_top.sv ====
// How it works
// - Eight-bit BCD: hundreds, then tens and ones.
// - Four-bit BCD: three strobes, low nibble each.
// - Digits combine into message number 0 to 255.
// - Nine-bit BCD never yields 200 or more.
// - Nine-bit BCD: select line adds hundred.
// - Port data accepted only at data level.
// - Per-line mode reports each line's edges.
// - Line n maps to n+1 or n+11.
// - Value must stay stable for sample time.
// - Debounce spaces per-line requests.
// - Round-robin scan from highest line downward.
// - Unprogrammed number becomes default or dropped.
// - Per-line power-up reports every active line.
// - Whole-value mode requests the new value.
// - Debounce spaces whole-value requests.
// - Whole-value power-up requests nonzero value only.
// - Polarity switches choose the active levels.
// - Strobe valid after three ms, debounce idle.
// - Data level suspends both automatic modes.
// - Message-level strobe aborts collecting message.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`default_nettype none
module pmrd_top #(
	parameter int TICK_CYC = pmrd_pkg::TICK_CYCLES
) (
	// Clock, reset and clock enable.
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	// Parallel port pins.
	input wire logic [7:0] port_data_lines,
	input wire logic strobe_line,
	input wire logic select_line,
	// Message engine side.
	input wire logic collecting,
	output logic req_valid,
	output logic [7:0] req_msg,
	output logic abort_msg,
	output logic data_valid,
	output logic [7:0] data_value,
	// AXI4-Lite write channels.
	input wire logic [pmrd_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [pmrd_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import pmrd_pkg::*;

	typedef struct packed {
		logic [2:0] mode;
		logic dpol;
		logic cpol;
		logic defen;
		logic [7:0] samp;
		logic [7:0] deb;
		logic [7:0] defmsg;
		logic [7:0] lastprog;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		pmrd_stb_t sst;
		logic [2:0] qcnt;
		logic [8:0] scnt;
		logic [DEB_CNT_W-1:0] dcnt;
		logic [1:0] digit;
		logic [3:0] hund;
		logic [3:0] tens;
		logic [7:0] snap;
		logic [7:0] cur;
		logic [2:0] ptr;
		logic req_valid;
		logic [7:0] req_msg;
		logic abort;
		logic dat_valid;
		logic [7:0] dat_byte;
		logic [7:0] req_cnt;
	} pmrd_st_t;

	pmrd_st_t st_reg, st_next;
	logic [9:0] sync_q;
	logic tick;

	if (TICK_CYC < 2) begin : g_chk
		$error("TICK_CYC must be at least 2");
	end

	// Pins cross into the core clock through two flops each.
	pmrd_sync #(.W(10)) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.d({select_line, strobe_line, port_data_lines}),
		.q(sync_q)
	);

	// Millisecond tick shared by the sample and debounce timers.
	pmrd_tick #(.CYC(TICK_CYC)) u_tick (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.tick(tick)
	);

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [9:0] bcd_num(input logic [3:0] h, input logic [3:0] t, input logic [3:0] o);
		return 10'(h) * 10'h064 + 10'(t) * 10'h00a + 10'(o);
	endfunction

	function automatic logic nib_ok(input logic [3:0] n);
		return n <= BCD_MAX;
	endfunction

	// A zero setting would disable the timer, so it is treated as the minimum.
	function automatic logic [8:0] samp_eff(input logic [7:0] s);
		return (s == 8'h00) ? 9'h001 : {1'b0, s};
	endfunction

	// One extra tick makes the spacing a true minimum despite tick phase.
	function automatic logic [DEB_CNT_W-1:0] deb_load(input logic [7:0] d);
		logic [11:0] u;
		u = (d == 8'h00) ? 12'h001 : {4'h0, d};
		return u * DEB_UNIT_MS + 12'h001;
	endfunction

	// Bit 8 set means a request goes out with the low byte as its number.
	function automatic logic [8:0] auto_resolve(input logic [7:0] n, input logic [7:0] last, input logic den,
			input logic [7:0] dmsg);
		if (n <= last) begin
			return {1'b1, n};
		end
		return {den, dmsg};
	endfunction

	// First changed line at or below the pointer, wrapping past line zero.
	function automatic logic [3:0] rr_pick(input logic [7:0] pend, input logic [2:0] from);
		logic [3:0] res;
		logic [2:0] k;
		res = 4'h0;
		k = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			k = from - 3'(i);
			if (pend[k]) begin
				res = {1'b1, k};
			end
		end
		return res;
	endfunction

	// Next state of the whole block.
	always_comb begin
		logic [7:0] din;
		logic stb_act;
		logic sel_data;
		logic [31:0] wv;
		logic [9:0] num;
		logic [8:0] res;
		logic [3:0] pk;
		logic [1:0] dg;
		logic amr;
		logic go;
		logic ok;
		din = '0;
		stb_act = 1'b0;
		sel_data = 1'b0;
		wv = '0;
		num = '0;
		res = '0;
		pk = '0;
		dg = '0;
		go = 1'b0;
		ok = 1'b0;
		amr = 1'b0;
		st_next = st_reg;
		st_next.req_valid = 1'b0;
		st_next.abort = 1'b0;
		st_next.dat_valid = 1'b0;
		din = st_reg.dpol ? sync_q[7:0] : ~sync_q[7:0];
		stb_act = st_reg.cpol ? sync_q[8] : ~sync_q[8];
		sel_data = st_reg.cpol ? sync_q[9] : ~sync_q[9];
		amr = (st_reg.mode == MODE_PER_LINE) || (st_reg.mode == MODE_WHOLE);

		// Debounce countdown, one step per millisecond.
		if (tick && st_reg.dcnt != '0) begin
			st_next.dcnt = st_reg.dcnt - DEB_CNT_W'(1);
		end

		// Write address and data are taken in either order and held.
		if (s_axi_awvalid && st_reg.awready) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_reg.wready) begin
			st_next.w_got = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
			case ({st_reg.aw_addr[ADDR_W-1:2], 2'h0})
				OFF_CTRL: begin
					wv = wmerge({26'h0, st_reg.defen, st_reg.cpol, st_reg.dpol, st_reg.mode}, st_reg.wdata,
						st_reg.wstrb);
					st_next.mode = wv[CTRL_MODE_LSB +: 3];
					st_next.dpol = wv[CTRL_DPOL_BIT];
					st_next.cpol = wv[CTRL_CPOL_BIT];
					st_next.defen = wv[CTRL_DEFEN_BIT];
					// A new configuration starts as if from power-up.
					st_next.cur = '0;
					st_next.ptr = PTR_RST;
					st_next.digit = '0;
					st_next.sst = ST_IDLE;
				end
				OFF_TIMING: begin
					wv = wmerge({16'h0, st_reg.deb, st_reg.samp}, st_reg.wdata, st_reg.wstrb);
					st_next.samp = wv[TIM_SAMP_LSB +: 8];
					st_next.deb = wv[TIM_DEB_LSB +: 8];
				end
				OFF_MSGCFG: begin
					wv = wmerge({16'h0, st_reg.lastprog, st_reg.defmsg}, st_reg.wdata, st_reg.wstrb);
					st_next.defmsg = wv[CFG_DEF_LSB +: 8];
					st_next.lastprog = wv[CFG_LAST_LSB +: 8];
				end
				OFF_STATUS: begin
					st_next.bresp = RESP_OKAY;
				end
				default: begin
					st_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Reads answer one cycle after the address is taken.
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st_reg.arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = '0;
			case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
				OFF_CTRL: begin
					st_next.rdata = {26'h0, st_reg.defen, st_reg.cpol, st_reg.dpol, st_reg.mode};
				end
				OFF_TIMING: begin
					st_next.rdata = {16'h0, st_reg.deb, st_reg.samp};
				end
				OFF_MSGCFG: begin
					st_next.rdata = {16'h0, st_reg.lastprog, st_reg.defmsg};
				end
				OFF_STATUS: begin
					st_next.rdata[STAT_MSG_LSB +: 8] = st_reg.req_msg;
					st_next.rdata[STAT_CNT_LSB +: 8] = st_reg.req_cnt;
					st_next.rdata[STAT_PORT_LSB +: 8] = din;
					st_next.rdata[STAT_BUSY_BIT] = st_reg.dcnt != '0;
				end
				default: begin
					st_next.rresp = RESP_SLVERR;
				end
			endcase
		end

		// Strobed modes: qualify, wait the sample time, then take the port.
		if (amr) begin
			st_next.sst = ST_IDLE;
		end else begin
			case (st_reg.sst)
				ST_IDLE: begin
					if (stb_act && st_reg.dcnt == '0) begin
						st_next.sst = ST_QUAL;
						st_next.qcnt = '0;
					end
				end
				ST_QUAL: begin
					// Ticks arrive at any phase, so one more than the minimum is counted.
					if (!stb_act) begin
						st_next.sst = ST_IDLE;
					end else if (tick && st_reg.qcnt == STB_MIN_MS) begin
						st_next.sst = ST_SAMP;
						st_next.scnt = '0;
					end else if (tick) begin
						st_next.qcnt = st_reg.qcnt + 3'h1;
					end
				end
				ST_SAMP: begin
					if (tick && st_reg.scnt == samp_eff(st_reg.samp)) begin
						st_next.sst = ST_HOLD;
						if (collecting && sel_data) begin
							st_next.dat_valid = 1'b1;
							st_next.dat_byte = (st_reg.mode == MODE_BCD4) ? {4'h0, din[3:0]} : din;
						end else if (!sel_data || st_reg.mode == MODE_BCD9) begin
							st_next.abort = collecting;
							dg = collecting ? 2'h0 : st_reg.digit;
							case (st_reg.mode)
								MODE_BCD9: begin
									num = bcd_num({3'h0, sel_data}, din[7:4], din[3:0]);
									ok = nib_ok(din[7:4]) && nib_ok(din[3:0]);
									go = 1'b1;
								end
								MODE_BCD8: begin
									if (dg == 2'h0) begin
										st_next.hund = din[3:0];
										st_next.digit = 2'h1;
									end else begin
										num = bcd_num(st_reg.hund, din[7:4], din[3:0]);
										ok = nib_ok(st_reg.hund) && nib_ok(din[7:4]) && nib_ok(din[3:0]);
										go = 1'b1;
										st_next.digit = 2'h0;
									end
								end
								MODE_BCD4: begin
									if (dg == 2'h0) begin
										st_next.hund = din[3:0];
										st_next.digit = 2'h1;
									end else if (dg == 2'h1) begin
										st_next.tens = din[3:0];
										st_next.digit = 2'h2;
									end else begin
										num = bcd_num(st_reg.hund, st_reg.tens, din[3:0]);
										ok = nib_ok(st_reg.hund) && nib_ok(st_reg.tens) && nib_ok(din[3:0]);
										go = 1'b1;
										st_next.digit = 2'h0;
									end
								end
								default: begin
									st_next.digit = 2'h0;
								end
							endcase
							// A bad digit or a number past the top drops the request.
							if (go && ok && num <= MSG_MAX) begin
								st_next.req_valid = 1'b1;
								st_next.req_msg = num[7:0];
								st_next.req_cnt = st_reg.req_cnt + 8'h01;
							end
						end
					end else if (tick) begin
						st_next.scnt = st_reg.scnt + 9'h001;
					end
				end
				ST_HOLD: begin
					// Debounce starts only when the strobe is released.
					if (!stb_act) begin
						st_next.sst = ST_IDLE;
						st_next.dcnt = deb_load(st_reg.deb);
					end
				end
				default: begin
					st_next.sst = ST_IDLE;
				end
			endcase
		end

		// Automatic modes: restart the sample time on any change or while suspended.
		if (amr) begin
			if (sel_data || din != st_reg.snap) begin
				st_next.snap = din;
				st_next.scnt = '0;
			end else if (tick && st_reg.scnt <= samp_eff(st_reg.samp)) begin
				st_next.scnt = st_reg.scnt + 9'h001;
			end
			if (!sel_data && din == st_reg.snap && st_reg.scnt > samp_eff(st_reg.samp) && st_reg.dcnt == '0) begin
				if (st_reg.mode == MODE_WHOLE && st_reg.snap != st_reg.cur) begin
					st_next.cur = st_reg.snap;
					res = auto_resolve(st_reg.snap, st_reg.lastprog, st_reg.defen, st_reg.defmsg);
					go = res[8];
				end else if (st_reg.mode == MODE_PER_LINE) begin
					pk = rr_pick(st_reg.snap ^ st_reg.cur, st_reg.ptr);
					if (pk[3]) begin
						st_next.cur[pk[2:0]] = st_reg.snap[pk[2:0]];
						st_next.ptr = pk[2:0] - 3'h1;
						num[7:0] = {5'h00, pk[2:0]} + (st_reg.snap[pk[2:0]] ? PL_ACT_BASE : PL_INACT_BASE);
						res = auto_resolve(num[7:0], st_reg.lastprog, st_reg.defen, st_reg.defmsg);
						go = res[8];
					end
				end
				if (go) begin
					st_next.req_valid = 1'b1;
					st_next.req_msg = res[7:0];
					st_next.req_cnt = st_reg.req_cnt + 8'h01;
					st_next.dcnt = deb_load(st_reg.deb);
				end
			end
		end

		// Ready flags are registered so every bus output comes from a flop.
		st_next.awready = !st_next.aw_got && !st_next.bvalid;
		st_next.wready = !st_next.w_got && !st_next.bvalid;
		st_next.arready = !st_next.rvalid;
	end

	// State register; reset clears the timers and loads the defaults.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.mode <= MODE_RST;
			st_reg.samp <= SAMP_RST;
			st_reg.deb <= DEB_RST;
			st_reg.defmsg <= DEFMSG_RST;
			st_reg.lastprog <= LASTPROG_RST;
			st_reg.ptr <= PTR_RST;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register.
	assign req_valid = st_reg.req_valid;
	assign req_msg = st_reg.req_msg;
	assign abort_msg = st_reg.abort;
	assign data_valid = st_reg.dat_valid;
	assign data_value = st_reg.dat_byte;
	assign s_axi_awready = st_reg.awready;
	assign s_axi_wready = st_reg.wready;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = st_reg.arready;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
endmodule
`default_nettype wire

// ==== bench/pmrd_assertions.sv ====
`default_nettype none
module pmrd_assertions #(
	parameter int TICK_CYC = pmrd_pkg::TICK_CYCLES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic srst,
	// Request side.
	input wire logic collecting,
	input wire logic req_valid,
	input wire logic [7:0] req_msg,
	input wire logic abort_msg,
	input wire logic data_valid,
	// Register bus answers.
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pmrd_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	timeunit 1ns;
	timeprecision 1ps;
	import pmrd_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	// Cycles since the last request; it saturates so long quiet spans stay legal.
	logic [19:0] gap_reg;
	logic [19:0] gap_next;
	always_comb begin
		gap_next = (gap_reg == 20'hfffff) ? gap_reg : gap_reg + 20'h00001;
		if (req_valid) begin
			gap_next = 20'h00000;
		end
	end
	always_ff @(posedge core_clk) begin
		gap_reg <= srst ? 20'hfffff : gap_next;
	end
	// Even the shortest debounce keeps two requests more than ten ticks apart.
	AST_REQ_SPACING: assert property (req_valid |-> gap_reg >= 20'(10 * TICK_CYC))
		else $error("requests too close");
	AST_REQ_MSG_HOLD: assert property (!req_valid |-> $stable(req_msg))
		else $error("message number moved without a request");
	AST_RESET_QUIET: assert property ($fell(srst) |-> !req_valid && !abort_msg && !data_valid && !s_axi_rvalid)
		else $error("output active after reset");
	AST_ABORT_CAUSE: assert property (abort_msg |-> !data_valid && ($past(collecting) || $past(collecting, 2)))
		else $error("abort without a collecting message");
	AST_DATA_CAUSE: assert property (data_valid |-> !req_valid && ($past(collecting) || $past(collecting, 2)))
		else $error("data item without a collecting message");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[4]
		|-> ##1 (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0))
		else $error("unmapped read not refused");
	// Main scenarios seen at least once.
	COV_REQ: cover property (req_valid);
	COV_ABORT: cover property (abort_msg);
	COV_DATA: cover property (data_valid);
endmodule
bind pmrd_top pmrd_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.*);
`default_nettype wire

// ==== bench/pmrd_partner.sv ====
`default_nettype none
module pmrd_partner #(
	parameter int TK = 20
) (
	// Clock.
	input wire logic core_clk,
	// Polarity switches as set in the control register.
	input wire logic cpol,
	input wire logic dpol,
	// Pins toward the decoder.
	output logic [7:0] port_data_lines,
	output logic strobe_line,
	output logic select_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// Logical state of the controller; the pins follow through the polarity switches.
	logic [7:0] val = 8'h00;
	logic dlvl = 1'b0;
	logic stb = 1'b0;
	assign port_data_lines = dpol ? val : ~val;
	assign strobe_line = stb ~^ cpol;
	assign select_line = dlvl ~^ cpol;
	// Contacts or relays simply hold a new level.
	task automatic put(input logic [7:0] v, input logic dl);
		val <= v;
		dlvl <= dl;
	endtask
	// Lines settle first, the strobe stays well past 3 ms, then debounce is awaited.
	task automatic strobe(input logic [7:0] v, input logic dl);
		put(v, dl);
		repeat (TK) @(posedge core_clk);
		stb <= 1'b1;
		repeat (7 * TK) @(posedge core_clk);
		stb <= 1'b0;
		val <= ~v;
		repeat (14 * TK) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// ==== bench/parallel_message_request_decoder_test.sv ====
`default_nettype none
module parallel_message_request_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pmrd_pkg::*;
	localparam int TK = 20;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic collecting = 1'b0;
	logic cpol = 1'b0;
	logic dpol = 1'b0;
	logic [7:0] port_data_lines, req_msg, data_value;
	logic strobe_line, select_line, req_valid, abort_msg, data_valid;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int nabort = 0;
	int tp = 0;
	int tl = 0;
	logic [31:0] rs = 32'hb1c7;
	logic [7:0] reqq[$];
	logic [7:0] dq[$];
	int tq[$];
	pmrd_top #(.TICK_CYC(TK)) u_dut (.ce(1'b1), .s_axi_wstrb(4'hf), .*);
	pmrd_partner #(.TK(TK)) u_far (.*);
	always #10 core_clk = ~core_clk;
	// Record every request with its cycle so spacing can be judged afterwards.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (req_valid === 1'b1) begin
			reqq.push_back(req_msg);
			tq.push_back(cyc);
		end
		if (abort_msg === 1'b1) nabort++;
		if (data_valid === 1'b1) dq.push_back(data_value);
	end
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Tens and ones of a number as two packed digits.
	function automatic logic [7:0] bcd(input int n);
		return 8'((n % 100 / 10) * 16 + n % 10);
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// An empty queue yields unknowns, so a missing request cannot match.
	task automatic take(input logic [7:0] e);
		logic [7:0] v;
		v = 8'hxx;
		tp = tl;
		if (reqq.size() != 0) begin
			v = reqq.pop_front();
			tl = tq.pop_front();
		end
		chk("request", {24'h0, v}, {24'h0, e});
	endtask
	task automatic none();
		chk("extra requests", reqq.size(), 32'h0);
		reqq.delete();
		tq.delete();
	endtask
	task automatic ms(input int n);
		repeat (n * TK) @(posedge core_clk);
	endtask
	// Address and data offered together; each is released once taken.
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || w) begin
			@(posedge core_clk);
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		chk("write response", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		chk("read data", s_axi_rdata, ed);
		chk("read response", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic cfg(input logic [2:0] m, input logic dp, input logic cp, input logic de);
		dpol <= dp;
		cpol <= cp;
		wr(OFF_CTRL, {26'h0, de, cp, dp, m}, RESP_OKAY);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// A hang counts as a mismatch and ends the run the usual way.
	initial begin
		repeat (60000) @(posedge core_clk);
		n_mismatch++;
		close_out();
	end
	initial begin
		int n;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		rd(OFF_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_TIMING, 32'h0505, RESP_OKAY);
		rd(OFF_MSGCFG, 32'hff00, RESP_OKAY);
		rd(5'h10, 32'h0, RESP_SLVERR);
		wr(5'h14, 32'h1, RESP_SLVERR);
		wr(OFF_TIMING, 32'h0101, RESP_OKAY);
		rd(OFF_TIMING, 32'h0101, RESP_OKAY);
		$display("registers done");
		cfg(MODE_BCD8, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			n = (i == 0) ? 255 : rnd() % 256;
			u_far.strobe(8'((rnd() & 32'hf0) | n / 100), 1'b0);
			u_far.strobe(bcd(n), 1'b0);
			take(8'(n));
		end
		u_far.strobe(8'h01, 1'b0);
		u_far.strobe(8'h3a, 1'b0);
		none();
		$display("eight bit done");
		cfg(MODE_BCD4, 1'b0, 1'b0, 1'b0);
		repeat (2) begin
			n = rnd() % 256;
			u_far.strobe(8'((rnd() & 32'hf0) | n / 100), 1'b0);
			u_far.strobe(8'((rnd() & 32'hf0) | n / 10 % 10), 1'b0);
			u_far.strobe(8'((rnd() & 32'hf0) | n % 10), 1'b0);
			take(8'(n));
		end
		$display("four bit done");
		cfg(MODE_BCD9, 1'b1, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++) begin
			n = (i == 0) ? 199 : rnd() % 200;
			u_far.strobe(bcd(n), n >= 100);
			take(8'(n));
		end
		collecting <= 1'b1;
		u_far.strobe(8'h42, 1'b1);
		u_far.strobe(8'h07, 1'b0);
		collecting <= 1'b0;
		take(8'h07);
		none();
		chk("data item", {24'h0, dq[0]}, 32'h42);
		chk("aborts", nabort, 32'h1);
		$display("nine bit done");
		u_far.put(8'h00, 1'b0);
		cfg(MODE_WHOLE, 1'b1, 1'b1, 1'b0);
		ms(20);
		none();
		n = rnd() % 255 + 1;
		u_far.put(8'(n), 1'b0);
		ms(5);
		u_far.put(8'(~n), 1'b0);
		ms(20);
		take(8'(n));
		take(8'(~n));
		chk("request spacing", 32'((tl - tp) > 10 * TK), 32'h1);
		u_far.put(8'h5a, 1'b0);
		repeat (10) @(posedge core_clk);
		u_far.put(8'(~n), 1'b0);
		ms(20);
		none();
		u_far.put(8'h33, 1'b1);
		ms(20);
		none();
		u_far.put(8'h33, 1'b0);
		ms(20);
		take(8'h33);
		cfg(MODE_WHOLE, 1'b0, 1'b1, 1'b1);
		wr(OFF_MSGCFG, 32'h402a, RESP_OKAY);
		ms(20);
		take(8'h33);
		u_far.put(8'h90, 1'b0);
		ms(20);
		take(8'h2a);
		cfg(MODE_WHOLE, 1'b1, 1'b1, 1'b0);
		ms(20);
		none();
		wr(OFF_MSGCFG, 32'hff00, RESP_OKAY);
		$display("whole value done");
		u_far.put(8'h81, 1'b0);
		cfg(MODE_PER_LINE, 1'b1, 1'b1, 1'b0);
		ms(40);
		take(8'h08);
		take(8'h01);
		chk("request spacing", 32'((tl - tp) > 10 * TK), 32'h1);
		u_far.put(8'h00, 1'b0);
		ms(40);
		take(8'h12);
		take(8'h0b);
		for (int i = 0; i < 8; i++) begin
			u_far.put(8'(1 << i), 1'b0);
			ms(15);
			take(8'(i + 1));
			u_far.put(8'h00, 1'b0);
			ms(15);
			take(8'(i + 11));
		end
		none();
		// Last number 18, 36 requests issued, port idle, debounce expired.
		rd(OFF_STATUS, 32'h00002412, RESP_OKAY);
		$display("per line done");
		close_out();
	end
endmodule
`default_nettype wire
